// ### src/fpc_pkg.sv
package fpc_pkg;

    // Register byte addresses
    localparam logic [7:0] FPC_A_MODE = 8'h00;
    localparam logic [7:0] FPC_A_CTRL = 8'h04;
    localparam logic [7:0] FPC_A_SET1 = 8'h08;
    localparam logic [7:0] FPC_A_CMP1H = 8'h0c;
    localparam logic [7:0] FPC_A_SET2 = 8'h10;
    localparam logic [7:0] FPC_A_CMP2H = 8'h14;
    localparam logic [7:0] FPC_A_CNTL = 8'h18;
    localparam logic [7:0] FPC_A_CNTH = 8'h1c;
    localparam logic [7:0] FPC_A_STAT = 8'h20;

    // Control register bits
    localparam int FPC_C_GATE1 = 0;
    localparam int FPC_C_IEN1 = 1;
    localparam int FPC_C_PRE1 = 3;
    localparam int FPC_C_GATE2 = 8;
    localparam int FPC_C_IEN2 = 9;
    localparam int FPC_C_PRE2 = 11;
    localparam int FPC_C_LOCK = 15;

    // Mode word fields
    localparam logic [1:0] FPC_M_CNT = 2'h3;
    localparam logic [1:0] FPC_M_INT = 2'h1;
    localparam int FPC_M_R1 = 2;
    localparam int FPC_M_F1 = 3;
    localparam int FPC_M_R2 = 6;
    localparam int FPC_M_F2 = 7;
    localparam int FPC_M_SPD = 10;
    localparam int FPC_M_QUAD = 11;
    localparam int FPC_M_CH1 = 12;
    localparam int FPC_M_CH2 = 13;

    // Input pin indices
    localparam int FPC_IN_A = 0;
    localparam int FPC_IN_B = 1;
    localparam int FPC_IN_R1 = 2;

    // Sampling time base
    localparam int FPC_CLK_HZ = 25_000_000;
    localparam int FPC_UNIT_MS = 10;
    localparam int FPC_TICK_CYC = FPC_CLK_HZ / 1000 * FPC_UNIT_MS;
    localparam logic [6:0] FPC_PER_MIN = 7'h01;
    localparam logic [6:0] FPC_PER_MAX = 7'h64;

    typedef enum logic [1:0] {
        FPC_OFF = 2'b00,
        FPC_UP = 2'b01,
        FPC_SPD = 2'b10,
        FPC_QUAD = 2'b11
    } fpc_mode_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] prev;
        logic [3:0] img;
        logic [3:0] freein;
        logic [15:0] mode_word;
        logic locked;
        fpc_mode_t mode;
        logic [1:0] chen;
        logic [1:0] iren;
        logic [1:0] gate;
        logic [1:0] gprev;
        logic [1:0] ien;
        logic [1:0][15:0] setv;
        logic [1:0][15:0] high;
        logic [1:0][15:0] cmpi;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] hold;
        logic [1:0][6:0] per;
        logic [31:0] q;
        logic [17:0] tick;
        logic [3:0] irq;
        logic [31:0] rdata;
    } fpc_state_t;

endpackage

// ### src/fpc_top.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module fpc_top #(
    parameter int unsigned SAMPLE_TICK_CYC = fpc_pkg::FPC_TICK_CYC
) (
    input wire logic pclk,               // 25 MHz clock
    input wire logic presetn,            // Async reset, active low
    input wire logic psel,               // APB select
    input wire logic penable,            // APB enable
    input wire logic pwrite,             // APB write
    input wire logic [7:0] paddr,        // APB byte address
    input wire logic [31:0] pwdata,      // APB write data
    output logic [31:0] prdata,          // APB read data
    output logic pready,                 // APB ready
    output logic pslverr,                // APB error, unmapped
    input wire logic [3:0] pin_in,       // Special inputs 0..3
    output logic [3:0] irq_req,          // Program 1..4 request pulses
    output logic [3:0] in_image,         // Ordinary input image
    output logic [3:0] in_free           // Inputs free for ordinary use
);
    import fpc_pkg::*;

    localparam logic [17:0] TICK_LAST = 18'(SAMPLE_TICK_CYC - 1);

    fpc_state_t r;
    fpc_state_t n;

    logic wr;
    logic rd;
    logic [1:0] pre;
    logic [3:0] rise;
    logic [3:0] fall;
    logic tick_en;
    logic [15:0] inc;
    logic [15:0] cmp;
    logic [6:0] lim;
    logic [31:0] qn;
    logic qchg;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == FPC_A_MODE) || (a == FPC_A_CTRL) ||
                  (a == FPC_A_SET1) || (a == FPC_A_CMP1H) ||
                  (a == FPC_A_SET2) || (a == FPC_A_CMP2H) ||
                  (a == FPC_A_CNTL) || (a == FPC_A_CNTH) ||
                  (a == FPC_A_STAT);
    endfunction

    function automatic logic [6:0] clamp_per(input logic [15:0] v);
        if (v < 16'(FPC_PER_MIN))
            clamp_per = FPC_PER_MIN;
        else if (v > 16'(FPC_PER_MAX))
            clamp_per = FPC_PER_MAX;
        else
            clamp_per = v[6:0];
    endfunction

    always_comb begin
        n = r;
        wr = psel & penable & pwrite;
        rd = psel & ~penable & ~pwrite;
        pre = 2'b00;
        inc = 16'h0000;
        cmp = 16'h0000;
        lim = FPC_PER_MIN;
        qn = r.q;
        qchg = 1'b0;

        // Two-stage sync, then edge history, then image a cycle later
        n.s1 = pin_in;
        n.s2 = r.s1;
        n.prev = r.s2;
        n.img = r.prev;
        rise = r.s2 & ~r.prev;
        fall = ~r.s2 & r.prev;
        n.irq = 4'h0;
        n.gprev = r.gate;

        tick_en = (r.tick == TICK_LAST);
        n.tick = tick_en ? 18'h00000 : r.tick + 18'h00001;

        if (wr) begin
            case (paddr)
                FPC_A_MODE: begin
                    if (!r.locked)
                        n.mode_word = pwdata[15:0];
                end
                FPC_A_CTRL: begin
                    n.gate = {pwdata[FPC_C_GATE2], pwdata[FPC_C_GATE1]};
                    n.ien = {pwdata[FPC_C_IEN2], pwdata[FPC_C_IEN1]};
                    pre = {pwdata[FPC_C_PRE2], pwdata[FPC_C_PRE1]};
                    if (pwdata[FPC_C_LOCK] && !r.locked) begin
                        n.locked = 1'b1;
                        if (r.mode_word[1:0] == FPC_M_CNT) begin
                            n.chen = {r.mode_word[FPC_M_CH2],
                                      r.mode_word[FPC_M_CH1]};
                            if (r.mode_word[FPC_M_QUAD])
                                n.mode = FPC_QUAD;
                            else if (r.mode_word[FPC_M_SPD])
                                n.mode = FPC_SPD;
                            else
                                n.mode = FPC_UP;
                        end else if (r.mode_word[1:0] == FPC_M_INT) begin
                            n.iren = {r.mode_word[FPC_M_CH2],
                                      r.mode_word[FPC_M_CH1]};
                        end
                    end
                end
                FPC_A_SET1: n.setv[0] = pwdata[15:0];
                FPC_A_CMP1H: n.high[0] = pwdata[15:0];
                FPC_A_SET2: n.setv[1] = pwdata[15:0];
                FPC_A_CMP2H: n.high[1] = pwdata[15:0];
                default: ;
            endcase
        end

        case (r.mode)
            FPC_UP: begin
                for (int i = 0; i < 2; i++) begin
                    if (r.chen[i]) begin
                        cmp = (r.gate[i] && !r.gprev[i]) ? r.setv[i]
                                                        : r.cmpi[i];
                        if (r.gate[i] && !r.gprev[i])
                            n.cmpi[i] = r.setv[i];
                        inc = r.cnt[i] + 16'h0001;
                        if (!r.gate[i]) begin
                            if (r.gprev[i])
                                n.cnt[i] = 16'h0000;
                            else if (pre[i])
                                n.cnt[i] = r.setv[i];
                        end else if (rise[FPC_IN_A + i]) begin
                            if (inc == cmp) begin
                                n.cnt[i] = 16'h0000;
                                n.irq[i] = r.ien[i];
                            end else begin
                                n.cnt[i] = inc;
                            end
                        end
                        if (r.s2[FPC_IN_R1 + i])
                            n.cnt[i] = 16'h0000;
                    end
                end
            end
            FPC_SPD: begin
                for (int i = 0; i < 2; i++) begin
                    if (r.chen[i]) begin
                        lim = clamp_per(r.setv[i]);
                        if (!r.gate[i]) begin
                            n.cnt[i] = 16'h0000;
                            n.hold[i] = 16'h0000;
                            n.per[i] = 7'h00;
                        end else begin
                            inc = rise[FPC_IN_A + i] ? r.cnt[i] + 16'h0001
                                                     : r.cnt[i];
                            n.cnt[i] = inc;
                            if (tick_en) begin
                                if (r.per[i] + 7'h01 >= lim) begin
                                    n.hold[i] = inc;
                                    n.cnt[i] = 16'h0000;
                                    n.per[i] = 7'h00;
                                end else begin
                                    n.per[i] = r.per[i] + 7'h01;
                                end
                            end
                        end
                    end
                end
            end
            FPC_QUAD: begin
                // Step when exactly one phase moved
                qchg = (rise[FPC_IN_A] | fall[FPC_IN_A]) ^
                       (rise[FPC_IN_B] | fall[FPC_IN_B]);
                if (!r.gate[0]) begin
                    if (r.gprev[0])
                        n.q = 32'h00000000;
                    else if (pre[0])
                        n.q = {r.high[0], r.setv[0]};
                    else if (pre[1])
                        n.q = {r.high[1], r.setv[1]};
                end else if (qchg) begin
                    if (r.s2[FPC_IN_A] ^ r.prev[FPC_IN_B])
                        qn = r.q + 32'h00000001;
                    else
                        qn = r.q - 32'h00000001;
                    n.q = qn;
                    for (int i = 0; i < 2; i++) begin
                        if (qn == {r.high[i], r.setv[i]})
                            n.irq[i] = r.ien[i];
                    end
                end
                if (r.s2[FPC_IN_R1])
                    n.q = 32'h00000000;
            end
            default: ;
        endcase

        // Edge interrupt inputs, raised before the image moves
        if (r.locked && r.mode_word[1:0] == FPC_M_INT) begin
            n.irq[2] = r.iren[0] &
                ((r.mode_word[FPC_M_R1] & rise[FPC_IN_R1]) |
                 (r.mode_word[FPC_M_F1] & fall[FPC_IN_R1]));
            n.irq[3] = r.iren[1] &
                ((r.mode_word[FPC_M_R2] & rise[FPC_IN_R1 + 1]) |
                 (r.mode_word[FPC_M_F2] & fall[FPC_IN_R1 + 1]));
        end

        // Pins left over for ordinary use
        n.freein = 4'hf;
        case (r.mode)
            FPC_UP: begin
                for (int i = 0; i < 2; i++) begin
                    if (r.chen[i]) begin
                        n.freein[FPC_IN_A + i] = 1'b0;
                        n.freein[FPC_IN_R1 + i] = 1'b0;
                    end
                end
            end
            FPC_SPD: begin
                for (int i = 0; i < 2; i++) begin
                    if (r.chen[i])
                        n.freein[FPC_IN_A + i] = 1'b0;
                end
            end
            FPC_QUAD: n.freein = 4'h8;
            default: begin
                for (int i = 0; i < 2; i++) begin
                    if (r.iren[i])
                        n.freein[FPC_IN_R1 + i] = 1'b0;
                end
            end
        endcase

        // Read data latched in the setup phase
        if (rd) begin
            n.rdata = 32'h00000000;
            case (paddr)
                FPC_A_MODE: n.rdata[15:0] = r.mode_word;
                FPC_A_CTRL: begin
                    n.rdata[FPC_C_GATE1] = r.gate[0];
                    n.rdata[FPC_C_IEN1] = r.ien[0];
                    n.rdata[FPC_C_GATE2] = r.gate[1];
                    n.rdata[FPC_C_IEN2] = r.ien[1];
                    n.rdata[FPC_C_LOCK] = r.locked;
                end
                FPC_A_SET1: n.rdata[15:0] = r.setv[0];
                FPC_A_CMP1H: n.rdata[15:0] = r.high[0];
                FPC_A_SET2: n.rdata[15:0] = r.setv[1];
                FPC_A_CMP2H: n.rdata[15:0] = r.high[1];
                FPC_A_CNTL: begin
                    if (r.mode == FPC_QUAD)
                        n.rdata[15:0] = r.q[15:0];
                    else if (r.mode == FPC_SPD)
                        n.rdata[15:0] = r.hold[0];
                    else
                        n.rdata[15:0] = r.cnt[0];
                end
                FPC_A_CNTH: begin
                    if (r.mode == FPC_QUAD)
                        n.rdata[15:0] = r.q[31:16];
                    else if (r.mode == FPC_SPD)
                        n.rdata[15:0] = r.hold[1];
                    else
                        n.rdata[15:0] = r.cnt[1];
                end
                FPC_A_STAT: n.rdata[15:0] = {r.img, r.freein, 5'h00,
                                             r.mode, r.locked};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.freein <= 4'hf;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok(paddr);
    assign irq_req = r.irq;
    assign in_image = r.img;
    assign in_free = r.freein;

endmodule

// ### testbench/fpc_pulse_src.sv
`timescale 1ns/1ns
module fpc_pulse_src (
    input wire logic pclk, // System clock
    output logic [3:0] pin_in // Encoder and switch lines
);
    initial pin_in = 4'h0;
    // Each level held 4 clocks, above the 2-clock minimum
    task automatic set_pin(input int k, input logic v);
        @(posedge pclk);
        pin_in[k] <= v;
        repeat (3) @(posedge pclk);
    endtask
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            set_pin(k, 1'b1);
            set_pin(k, 1'b0);
        end
    endtask
    // One full cycle, phase A leading when up is set
    task automatic quad(input logic up);
        set_pin(up ? 0 : 1, 1'b1);
        set_pin(up ? 1 : 0, 1'b1);
        set_pin(up ? 0 : 1, 1'b0);
        set_pin(up ? 1 : 0, 1'b0);
    endtask
endmodule

// ### testbench/fpc_sva.sv
`timescale 1ns/1ns
module fpc_sva #(
    parameter int unsigned SAMPLE_TICK_CYC = 8
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [3:0] pin_in, // Special inputs
    input wire logic [3:0] irq_req, // Program requests
    input wire logic [3:0] in_image, // Input image
    input wire logic [3:0] in_free // Free inputs
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_bad;
        psel && penable && paddr > 8'h20;
    endsequence
    property p_err;
        s_bad |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok;
        s_acc ##0 (paddr <= 8'h20 && paddr[1:0] == 2'h0) |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_rd0;
        s_bad ##0 !pwrite |-> prdata == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
    property p_hold;
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_once;
        irq_req != 4'h0 |=> (irq_req & $past(irq_req)) == 4'h0;
    endproperty
    a_once: assert property (p_once) else $error("request too long");
    property p_cnt_cause;
        irq_req[1:0] != 2'h0 |->
            $past(pin_in[1:0], 3) != $past(pin_in[1:0], 4);
    endproperty
    a_cnt_cause: assert property (p_cnt_cause) else $error("count req");
    property p_in_cause;
        irq_req[3:2] != 2'h0 |->
            $past(pin_in[3:2], 3) != $past(pin_in[3:2], 4);
    endproperty
    a_in_cause: assert property (p_in_cause) else $error("input req");
    property p_late_image;
        irq_req[2] |=> in_image[2] != $past(in_image[2]);
    endproperty
    a_late_image: assert property (p_late_image) else $error("image");
endmodule
bind fpc_top fpc_sva #(.SAMPLE_TICK_CYC(SAMPLE_TICK_CYC)) u_fpc_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .irq_req(irq_req), .in_image(in_image), .in_free(in_free)
);

// ### testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import fpc_pkg::*;
    localparam int unsigned TICK = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [3:0] pin_in, irq_req, in_image, in_free;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int ic [4] = '{0, 0, 0, 0};
    fpc_top #(.SAMPLE_TICK_CYC(TICK)) u_fpc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .irq_req(irq_req), .in_image(in_image), .in_free(in_free)
    );
    fpc_pulse_src u_fpc_pulse_src (
        .pclk(pclk),
        .pin_in(pin_in)
    );
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    // Requests counted mid-cycle, clear of the launching edge
    always @(negedge pclk) begin
        for (int k = 0; k < 4; k++) begin
            if (irq_req[k] === 1'b1) ic[k] <= ic[k] + 1;
        end
    end
    task automatic close_out();
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setup(input logic [31:0] mode);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, FPC_A_MODE, mode);
        apb(1'b1, FPC_A_CTRL, 32'h8000);
    endtask
    task automatic rd_cnt(input logic [7:0] a, input logic [15:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v[15:0], exp);
    endtask
    task automatic t_up();
        int n;
        chk(in_free, 4'hf);
        apb(1'b1, FPC_A_SET1, 32'hbeef);
        rd_cnt(FPC_A_SET1, 16'hbeef);
        apb(1'b1, FPC_A_CNTL, 32'h1234);
        rd_cnt(FPC_A_CNTL, 16'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd_e, rd_v[30:0]}, 32'h80000000);
        setup(32'h1003);
        rd_cnt(FPC_A_STAT, 16'h0a03);
        apb(1'b1, FPC_A_MODE, 32'h0803);
        rd_cnt(FPC_A_STAT, 16'h0a03);
        apb(1'b1, FPC_A_SET1, 32'h3);
        apb(1'b1, FPC_A_CTRL, 32'h3);
        apb(1'b1, FPC_A_SET1, 32'h64);
        n = ic[0];
        u_fpc_pulse_src.pulse(0, 2);
        rd_cnt(FPC_A_CNTL, 16'h2);
        u_fpc_pulse_src.pulse(0, 1);
        rd_cnt(FPC_A_CNTL, 16'h0);
        chk(ic[0] - n, 1);
        u_fpc_pulse_src.pulse(0, 1);
        u_fpc_pulse_src.set_pin(2, 1'b1);
        rd_cnt(FPC_A_CNTL, 16'h0);
        u_fpc_pulse_src.set_pin(2, 1'b0);
        u_fpc_pulse_src.pulse(0, 1);
        apb(1'b1, FPC_A_CTRL, 32'h0);
        u_fpc_pulse_src.pulse(0, 1);
        rd_cnt(FPC_A_CNTL, 16'h0);
        apb(1'b1, FPC_A_SET1, 32'hffff);
        apb(1'b1, FPC_A_CTRL, 32'h8);
        rd_cnt(FPC_A_CNTL, 16'hffff);
    endtask
    task automatic t_spd();
        int n;
        setup(32'h1403);
        apb(1'b1, FPC_A_SET1, 32'h5);
        chk(in_free, 4'he);
        apb(1'b1, FPC_A_CTRL, 32'h3);
        n = ic[0];
        fork
            u_fpc_pulse_src.pulse(0, 20);
            begin
                repeat (100) @(posedge pclk);
                apb(1'b0, FPC_A_CNTL, 32'h0);
            end
        join
        chk(rd_v[15:0], 16'h5);
        chk(ic[0] - n, 0);
        apb(1'b1, FPC_A_CTRL, 32'h0);
        rd_cnt(FPC_A_CNTL, 16'h0);
    endtask
    task automatic t_quad();
        int n, m;
        setup(32'h0803);
        apb(1'b1, FPC_A_SET2, 32'hffff);
        chk(in_free, 4'h8);
        apb(1'b1, FPC_A_CMP2H, 32'hffff);
        apb(1'b1, FPC_A_CTRL, 32'h203);
        apb(1'b1, FPC_A_SET1, 32'h4);
        apb(1'b1, FPC_A_CMP1H, 32'h0);
        n = ic[0];
        m = ic[1];
        u_fpc_pulse_src.quad(1'b1);
        rd_cnt(FPC_A_CNTL, 16'h4);
        chk(ic[0] - n, 1);
        u_fpc_pulse_src.quad(1'b0);
        u_fpc_pulse_src.set_pin(1, 1'b1);
        rd_cnt(FPC_A_CNTL, 16'hffff);
        rd_cnt(FPC_A_CNTH, 16'hffff);
        chk(ic[1] - m, 1);
        u_fpc_pulse_src.set_pin(2, 1'b1);
        u_fpc_pulse_src.set_pin(2, 1'b0);
        rd_cnt(FPC_A_CNTH, 16'h0);
        apb(1'b1, FPC_A_CTRL, 32'h0);
        apb(1'b1, FPC_A_CTRL, 32'h800);
        rd_cnt(FPC_A_CNTL, 16'hffff);
    endtask
    task automatic t_edge();
        int n, m;
        setup(32'h3045);
        n = ic[2];
        m = ic[3];
        u_fpc_pulse_src.pulse(2, 1);
        u_fpc_pulse_src.pulse(3, 1);
        chk(ic[2] - n, 1);
        chk(ic[3] - m, 1);
        setup(32'h1009);
        n = ic[2];
        u_fpc_pulse_src.pulse(2, 1);
        chk(ic[2] - n, 0);
        repeat (2) @(posedge pclk);
        chk(ic[2] - n, 1);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_up();
        t_spd();
        t_quad();
        t_edge();
        close_out();
    end
endmodule
